// File: rtl/gio4_defs.vh
// Constants of the four-bit global port: register offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`ifndef GIO4_DEFS_VH
`define GIO4_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define GIO4_DATA_OFS 8'h00
`define GIO4_DIR_OFS 8'h04
`define GIO4_OPT_OFS 8'h08
`define GIO4_STAT_OFS 8'h0c

// ****************************************
// Option register fields
// ****************************************
`define GIO4_OPT_PD_DIS 3
`define GIO4_OPT_OD_SEL 2
`define GIO4_OPT_STB_HI 1
`define GIO4_OPT_STB_LO 0

// ****************************************
// Reset values
// ****************************************
`define GIO4_DIR_RST 1'h0
`define GIO4_OPT_RST 4'h0
`define GIO4_DATA_RST 4'h0

// ****************************************
// Power saving hint timing
// ****************************************
`define GIO4_PULL_MIN_CLK 4
`define GIO4_PULL_NOP_CLK 6

`endif

// File: rtl/gio4_pad_ctrl.v
// Per-terminal pad control: drive enable, drive level and pull enables.
// Assumes registered controls from the same clock; outputs are registered.
module gio4_pad_ctrl #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Controls
    input wire dir_out,
    input wire open_drain,
    input wire pd_disable,
    input wire sleep,
    input wire [WIDTH-1:0] data,
    input wire [WIDTH-1:0] pu_mask,
    input wire [WIDTH-1:0] pd_mask,
    // Pad side
    output reg [WIDTH-1:0] pad_out,
    output reg [WIDTH-1:0] pad_oe,
    output reg [WIDTH-1:0] pull_up_en,
    output reg [WIDTH-1:0] pull_down_en
);

    reg [WIDTH-1:0] oe_nxt;
    reg [WIDTH-1:0] out_nxt;
    reg [WIDTH-1:0] pu_nxt;
    reg [WIDTH-1:0] pd_nxt;

    always @* begin
        if (open_drain) begin
            out_nxt = {WIDTH{1'b0}};
            oe_nxt = dir_out ? ~data : {WIDTH{1'b0}};
        end else begin
            out_nxt = data;
            oe_nxt = {WIDTH{dir_out}};
        end
        pu_nxt = pu_mask & {WIDTH{open_drain}} & ({WIDTH{~dir_out}} | data);
        pd_nxt = pd_mask & {WIDTH{~pd_disable & ~open_drain}};
        if (dir_out && !open_drain) begin
            pd_nxt = {WIDTH{1'b0}};
        end
        pd_nxt = pd_nxt & ~pu_nxt;
        if (sleep) begin
            oe_nxt = {WIDTH{1'b0}};
            pu_nxt = {WIDTH{1'b0}};
            pd_nxt = {WIDTH{1'b0}};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pad_out <= {WIDTH{1'b0}};
            pad_oe <= {WIDTH{1'b0}};
            pull_up_en <= {WIDTH{1'b0}};
            pull_down_en <= {WIDTH{1'b0}};
        end else begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pull_up_en <= pu_nxt;
            pull_down_en <= pd_nxt;
        end
    end

endmodule // gio4_pad_ctrl

// File: rtl/gio4_port.v
// Four-bit global port with AHB-Lite register access.
// Assumes pins asynchronous to hclk, a single AHB-Lite master, zero-wait-state answers.
module gio4_port #(
    parameter WIDTH = 4,
    parameter [3:0] PU_MASK = 4'hf,
    parameter [3:0] PD_MASK = 4'hf
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Power mode
    input wire sleep_req,
    // Port terminals
    input wire [WIDTH-1:0] port_terminals_in,
    output wire [WIDTH-1:0] port_terminals_out,
    output wire [WIDTH-1:0] port_terminals_oe,
    output wire [WIDTH-1:0] pull_up_en,
    output wire [WIDTH-1:0] pull_down_en
);

`include "gio4_defs.vh"

    // ****************************************
    // Address decode
    // ****************************************
    localparam SEL_DATA = 0;
    localparam SEL_DIR = 1;
    localparam SEL_OPT = 2;
    localparam SEL_STAT = 3;

    // One-hot register select from a byte address
    function [3:0] gio4_dec;
        input [7:0] addr;
        begin
            gio4_dec = 4'h0;
            if (addr == `GIO4_DATA_OFS) begin
                gio4_dec[SEL_DATA] = 1'b1;
            end else if (addr == `GIO4_DIR_OFS) begin
                gio4_dec[SEL_DIR] = 1'b1;
            end else if (addr == `GIO4_OPT_OFS) begin
                gio4_dec[SEL_OPT] = 1'b1;
            end else if (addr == `GIO4_STAT_OFS) begin
                gio4_dec[SEL_STAT] = 1'b1;
            end
        end
    endfunction

    // ****************************************
    // Synchronisers
    // ****************************************
    reg [WIDTH-1:0] pin_s1_r;
    reg [WIDTH-1:0] pin_s2_r;
    reg sleep_s1_r;
    reg sleep_s2_r;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1_r <= {WIDTH{1'b0}};
            pin_s2_r <= {WIDTH{1'b0}};
            sleep_s1_r <= 1'b0;
            sleep_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= port_terminals_in;
            pin_s2_r <= pin_s1_r;
            sleep_s1_r <= sleep_req;
            sleep_s2_r <= sleep_s1_r;
        end
    end

    // ****************************************
    // Bus address phase capture
    // ****************************************
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    wire take;
    wire take_wr;
    wire take_rd;

    // ****************************************
    // Transfer qualifiers
    // ****************************************
    assign take = hsel & hready & htrans[1];
    assign take_wr = take & hwrite;
    assign take_rd = take & ~hwrite;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take_wr;
            if (take) begin
                wr_addr_r <= haddr;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    reg [WIDTH-1:0] port_data_reg_r;
    reg port_direction_reg_r;
    reg [3:0] port_option_reg_r;
    reg [WIDTH-1:0] port_data_reg_nxt;
    reg port_direction_reg_nxt;
    reg [3:0] port_option_reg_nxt;
    wire [3:0] wr_sel;

    assign wr_sel = gio4_dec(wr_addr_r);

    // Next register values from the write data phase
    always @* begin
        port_data_reg_nxt = port_data_reg_r;
        port_direction_reg_nxt = port_direction_reg_r;
        port_option_reg_nxt = port_option_reg_r;
        if (wr_pend_r) begin
            if (wr_sel[SEL_DATA]) begin
                port_data_reg_nxt = hwdata[WIDTH-1:0];
            end else if (wr_sel[SEL_DIR]) begin
                port_direction_reg_nxt = hwdata[0];
            end else if (wr_sel[SEL_OPT]) begin
                port_option_reg_nxt = hwdata[3:0];
            end
        end
    end

    // ****************************************
    // Register flops
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_data_reg_r <= `GIO4_DATA_RST;
            port_direction_reg_r <= `GIO4_DIR_RST;
            port_option_reg_r <= `GIO4_OPT_RST;
        end else begin
            port_data_reg_r <= port_data_reg_nxt;
            port_direction_reg_r <= port_direction_reg_nxt;
            port_option_reg_r <= port_option_reg_nxt;
        end
    end

    // ****************************************
    // Status word
    // ****************************************
    wire [31:0] stat_word;

    assign stat_word = {23'h000000, sleep_s2_r, {(8-WIDTH){1'b0}}, port_data_reg_r};

    // ****************************************
    // Read path
    // ****************************************
    reg [31:0] rd_nxt;
    wire [3:0] rd_sel;

    assign rd_sel = gio4_dec(haddr);

    always @* begin
        rd_nxt = 32'h00000000;
        if (rd_sel[SEL_DATA]) begin
            rd_nxt[WIDTH-1:0] = pin_s2_r;
        end else if (rd_sel[SEL_DIR]) begin
            rd_nxt[0] = port_direction_reg_r;
        end else if (rd_sel[SEL_OPT]) begin
            rd_nxt[3:0] = port_option_reg_r;
        end else if (rd_sel[SEL_STAT]) begin
            rd_nxt = stat_word;
        end
    end

    // ****************************************
    // Bus response
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (take_rd) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // ****************************************
    // Pad control fields
    // ****************************************
    wire port_direction_bit;
    wire open_drain_select;
    wire pulldown_disable;

    assign port_direction_bit = port_direction_reg_r;
    assign open_drain_select = port_option_reg_r[`GIO4_OPT_OD_SEL];
    assign pulldown_disable = port_option_reg_r[`GIO4_OPT_PD_DIS];

    // ****************************************
    // Pad control
    // ****************************************
    // drive select
    gio4_pad_ctrl #(
        .WIDTH(WIDTH)
    ) u_pad (
        .hclk(hclk),
        .hresetn(hresetn),
        .dir_out(port_direction_bit),
        .open_drain(open_drain_select),
        .pd_disable(pulldown_disable),
        .sleep(sleep_s2_r),
        .data(port_data_reg_r),
        .pu_mask(PU_MASK[WIDTH-1:0]),
        .pd_mask(PD_MASK[WIDTH-1:0]),
        .pad_out(port_terminals_out),
        .pad_oe(port_terminals_oe),
        .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en)
    );

endmodule // gio4_port

// File: tb/gio4_board.sv
// Board model of four port pins: pulls, external drivers, float.
// Assumes pad enables and levels come from the port under test.
module gio4_board (
    // Clock
    input wire clk,
    // Pad side
    input wire [3:0] oe,
    input wire [3:0] out,
    input wire [3:0] pu,
    input wire [3:0] pd,
    // Board drivers
    input wire [3:0] ext_en,
    input wire [3:0] ext_val,
    output logic [3:0] lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] flt = 4'h0;
    // Floating lines toggle every cycle
    always @(posedge clk) flt <= ~flt;
    assign lvl = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pu | (~pd & flt)));
endmodule // gio4_board

// File: tb/gio4_port_checker.sv
// Assertions on the port pins and bus answer of the four-bit port.
// Sees only the top-level ports; bound below.
module gio4_port_checker #(
    parameter [3:0] PU_MASK = 4'hf,
    parameter [3:0] PD_MASK = 4'hf
) (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // Port
    input wire sleep_req,
    input wire [3:0] port_terminals_in,
    input wire [3:0] port_terminals_oe,
    input wire [3:0] pull_up_en,
    input wire [3:0] pull_down_en
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd;
        hsel && hready && htrans[1] && !hwrite && haddr == 8'h00;
    endsequence
    sequence s_sleep;
        sleep_req [*5];
    endsequence
    property p_rd;
        $stable(port_terminals_in) [*3] ##0 s_rd |=> hrdata == {28'h0, $past(port_terminals_in)};
    endproperty
    a_rd: assert property (p_rd) else $error("pin read wrong");
    property p_sleep;
        s_sleep |-> (port_terminals_oe | pull_up_en | pull_down_en) == 4'h0;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep drive");
    property p_rst;
        $rose(hresetn) |-> port_terminals_oe == 4'h0 [*2];
    endproperty
    a_rst: assert property (p_rst) else $error("drive after reset");
    property p_excl;
        (pull_up_en & pull_down_en) == 4'h0;
    endproperty
    a_excl: assert property (p_excl) else $error("both pulls");
    property p_odpu;
        (port_terminals_oe & pull_up_en) == 4'h0;
    endproperty
    a_odpu: assert property (p_odpu) else $error("pull-up on driven pin");
    property p_drvpd;
        (port_terminals_oe & pull_down_en) == 4'h0;
    endproperty
    a_drvpd: assert property (p_drvpd) else $error("pull-down on driven pin");
    property p_mask;
        (pull_up_en & ~PU_MASK) == 4'h0 && (pull_down_en & ~PD_MASK) == 4'h0;
    endproperty
    a_mask: assert property (p_mask) else $error("pull without mask");
    property p_ok;
        hreadyout && !hresp;
    endproperty
    a_ok: assert property (p_ok) else $error("bus not ready or error");
endmodule // gio4_port_checker
bind gio4_port gio4_port_checker #(.PU_MASK(PU_MASK), .PD_MASK(PD_MASK)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_req(sleep_req), .port_terminals_in(port_terminals_in),
    .port_terminals_oe(port_terminals_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en));

// File: tb/tb.sv
// Self-checking bench of the four-bit port over AHB-Lite.
// Assumes zero-wait answers; the board model closes the pins.
`include "gio4_defs.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sleep_req = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, q;
    logic [3:0] ext_en = 4'h0, ext_val = 4'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp;
    wire [3:0] pin, out, oe, pu, pd;
    int n_errors = 0, cmp_count = 0, tn = 0;
    initial forever #12.5 hclk = ~hclk;
    gio4_port #(.WIDTH(4), .PU_MASK(4'ha), .PD_MASK(4'h5)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
        .port_terminals_in(pin), .port_terminals_out(out), .port_terminals_oe(oe),
        .pull_up_en(pu), .pull_down_en(pd));
    gio4_board i_brd (.clk(hclk), .oe(oe), .out(out), .pu(pu), .pd(pd),
        .ext_en(ext_en), .ext_val(ext_val), .lvl(pin));
    // ****
    // Tasks
    // ****
    task chk(input [31:0] got, input [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task xfer(input [7:0] a, input w, input [31:0] d, output [31:0] r);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        xfer(a, 0, 32'h0, q);
        chk(q, e);
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(a, 1, d, q);
    endtask
    task cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task pads(input [3:0] e_oe, input [3:0] e_out, input [3:0] e_pu, input [3:0] e_pd);
        cyc(2);
        chk({16'h0, oe, out & oe, pu, pd}, {16'h0, e_oe, e_out, e_pu, e_pd});
    endtask
    task tend;
        tn++;
        $display("test %0d done", tn);
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****
    // Tests
    // ****
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1;
        pads(4'h0, 4'h0, 4'h0, 4'h5);
        rd(`GIO4_DIR_OFS, 32'h0);
        rd(`GIO4_OPT_OFS, 32'h0);
        tend;
        ext_en <= 4'hf;
        ext_val <= 4'h9;
        cyc(4);
        rd(`GIO4_DATA_OFS, 32'h9);
        tend;
        ext_en <= 4'h0;
        wr(`GIO4_DATA_OFS, 32'h6);
        wr(`GIO4_DIR_OFS, 32'hffffffff);
        pads(4'hf, 4'h6, 4'h0, 4'h0);
        rd(`GIO4_DIR_OFS, 32'h1);
        rd(`GIO4_DATA_OFS, 32'h6);
        tend;
        ext_en <= 4'hf;
        ext_val <= 4'h0;
        wr(`GIO4_OPT_OFS, 32'h4);
        pads(4'h9, 4'h0, 4'h2, 4'h0);
        cyc(2);
        rd(`GIO4_DATA_OFS, 32'h0);
        rd(`GIO4_STAT_OFS, 32'h6);
        wr(`GIO4_DIR_OFS, 32'h0);
        pads(4'h0, 4'h0, 4'ha, 4'h0);
        tend;
        wr(`GIO4_OPT_OFS, 32'hb);
        pads(4'h0, 4'h0, 4'h0, 4'h0);
        rd(`GIO4_OPT_OFS, 32'hb);
        tend;
        wr(`GIO4_OPT_OFS, 32'h0);
        wr(`GIO4_DIR_OFS, 32'h1);
        sleep_req <= 1;
        cyc(4);
        pads(4'h0, 4'h0, 4'h0, 4'h0);
        rd(`GIO4_STAT_OFS, 32'h106);
        sleep_req <= 0;
        cyc(4);
        pads(4'hf, 4'h6, 4'h0, 4'h0);
        wr(8'h10, 32'hf);
        rd(8'h10, 32'h0);
        tend;
        ext_en <= 4'h0;
        wr(`GIO4_DIR_OFS, 32'h0);
        wr(`GIO4_OPT_OFS, 32'h0);
        cyc(4);
        xfer(`GIO4_DATA_OFS, 0, 32'h0, q);
        chk(q & 32'h5, 32'h0);
        wr(`GIO4_OPT_OFS, 32'h8);
        pads(4'h0, 4'h0, 4'h0, 4'h0);
        tend;
        wr(`GIO4_DIR_OFS, 32'h1);
        hresetn <= 0;
        cyc(2);
        hresetn <= 1;
        rd(`GIO4_DIR_OFS, 32'h0);
        rd(`GIO4_OPT_OFS, 32'h0);
        tend;
        close_out;
    end
    initial begin
        #(25 * 3000);
        n_errors++;
        close_out;
    end
endmodule // tb
